// file: core/bsj_defs.vh
// constants for the boundary-scan test port
`ifndef BSJ_DEFS_VH
`define BSJ_DEFS_VH
`define BSJ_IR_W 4
`define BSJ_OP_EXTEST 4'h0
`define BSJ_OP_SAMPLE 4'h1
`define BSJ_OP_IDCODE 4'h2
`define BSJ_OP_USERCODE 4'h3
`define BSJ_OP_CFG_START 4'h4
`define BSJ_OP_CFG_LOAD 4'h5
`define BSJ_OP_PROBE 4'h6
`define BSJ_OP_BYPASS 4'hF
`define BSJ_IR_CAPTURE 4'h1
`define BSJ_IDCODE_W 32
`define BSJ_USERCODE_W 32
// arbitrary neutral identity value, bit 0 set as the scan standard requires
`define BSJ_IDCODE_RST 32'h0000_0001
`define BSJ_USERCODE_RST 32'h0000_0000
`endif

// file: core/bsj_sync.v
// two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/10ps
module bsj_sync #(
	parameter W = 1
) (
	input wire clk,
	input wire nrst,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk) begin
		if (!nrst) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;
endmodule // bsj_sync

// file: core/bsj_tap.v
// boundary-scan test access port with configuration and probe paths
`timescale 1ns/10ps
`include "bsj_defs.vh"
// Function
// - tap state machine and data registers follow the 1149.1-1990 standard
// - scan usable before and after configuration; pin access blocked while configuring
// - test port also loads configuration data serially
// - sample/preload captures pins and preloads an output pattern
// - extest drives preloaded pattern on outputs and captures input pins
// - bypass puts one-bit register between serial input and output
// - usercode shifts out a 32-bit user code register
// - idcode shifts out the identification register
// - reconfiguration instructions start and feed device configuration
// - probe instruction shifts out internal signals for the analyzer
module bsj_tap #(
	parameter NI = 8,
	parameter NO = 8,
	parameter PW = 16,
	parameter [31:0] IDCODE = `BSJ_IDCODE_RST,
	parameter [31:0] USERCODE = `BSJ_USERCODE_RST
) (
	input wire clk,
	input wire nrst,
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo_q,
	output reg tdo_oe_n_q,
	input wire [NI-1:0] pin_in,
	input wire [NO-1:0] core_out,
	output reg [NO-1:0] pin_out_q,
	output reg extest_q,
	input wire cfg_busy,
	output reg cfg_start_q,
	output reg cfg_bit_q,
	output reg cfg_stb_q,
	input wire [PW-1:0] probe_in
);
	localparam BL = NI + NO;
	localparam [15:0] S_TLR = 16'h0001;
	localparam [15:0] S_RTI = 16'h0002;
	localparam [15:0] S_SDS = 16'h0004;
	localparam [15:0] S_CDR = 16'h0008;
	localparam [15:0] S_SDR = 16'h0010;
	localparam [15:0] S_E1D = 16'h0020;
	localparam [15:0] S_PDR = 16'h0040;
	localparam [15:0] S_E2D = 16'h0080;
	localparam [15:0] S_UDR = 16'h0100;
	localparam [15:0] S_SIS = 16'h0200;
	localparam [15:0] S_CIR = 16'h0400;
	localparam [15:0] S_SIR = 16'h0800;
	localparam [15:0] S_E1I = 16'h1000;
	localparam [15:0] S_PIR = 16'h2000;
	localparam [15:0] S_E2I = 16'h4000;
	localparam [15:0] S_UIR = 16'h8000;

	wire [NI+2:0] sync_w;
	wire s_tck;
	wire s_tms;
	wire s_tdi;
	wire [NI-1:0] s_pin;
	reg tck_prev_q;
	wire tck_rise;
	wire tck_fall;
	reg [15:0] state_q;
	reg [15:0] state_d;
	reg [`BSJ_IR_W-1:0] ir_q;
	reg [`BSJ_IR_W-1:0] ir_sh_q;
	reg byp_q;
	reg [31:0] id_sh_q;
	reg [BL-1:0] bsr_sh_q;
	reg [NO-1:0] bsr_upd_q;
	reg [PW-1:0] prb_sh_q;
	reg sel_ext;
	reg sel_smp;
	reg sel_id;
	reg sel_usr;
	reg sel_cfg;
	reg sel_prb;
	reg sel_byp;
	reg dr_out;

	bsj_sync #(.W(NI + 3)) u_sync (
		.clk(clk),
		.nrst(nrst),
		.d({pin_in, tdi, tms, tck}),
		.q(sync_w)
	);
	assign s_tck = sync_w[0];
	assign s_tms = sync_w[1];
	assign s_tdi = sync_w[2];
	assign s_pin = sync_w[NI+2:3];
	assign tck_rise = s_tck & ~tck_prev_q;
	assign tck_fall = ~s_tck & tck_prev_q;

	// instruction decode; pin access falls back to bypass while configuring
	always @* begin
		sel_ext = 1'b0;
		sel_smp = 1'b0;
		sel_id = 1'b0;
		sel_usr = 1'b0;
		sel_cfg = 1'b0;
		sel_prb = 1'b0;
		sel_byp = 1'b0;
		case (ir_q)
		`BSJ_OP_EXTEST: begin
			sel_ext = ~cfg_busy;
			sel_byp = cfg_busy;
		end
		`BSJ_OP_SAMPLE: begin
			sel_smp = ~cfg_busy;
			sel_byp = cfg_busy;
		end
		`BSJ_OP_IDCODE: sel_id = 1'b1;
		`BSJ_OP_USERCODE: sel_usr = 1'b1;
		`BSJ_OP_CFG_LOAD: sel_cfg = 1'b1;
		`BSJ_OP_PROBE: sel_prb = 1'b1;
		default: sel_byp = 1'b1;
		endcase
	end

	// standard sixteen-state controller stepped by tms
	always @* begin
		case (state_q)
		S_TLR: state_d = s_tms ? S_TLR : S_RTI;
		S_RTI: state_d = s_tms ? S_SDS : S_RTI;
		S_SDS: state_d = s_tms ? S_SIS : S_CDR;
		S_CDR: state_d = s_tms ? S_E1D : S_SDR;
		S_SDR: state_d = s_tms ? S_E1D : S_SDR;
		S_E1D: state_d = s_tms ? S_UDR : S_PDR;
		S_PDR: state_d = s_tms ? S_E2D : S_PDR;
		S_E2D: state_d = s_tms ? S_UDR : S_SDR;
		S_UDR: state_d = s_tms ? S_SDS : S_RTI;
		S_SIS: state_d = s_tms ? S_TLR : S_CIR;
		S_CIR: state_d = s_tms ? S_E1I : S_SIR;
		S_SIR: state_d = s_tms ? S_E1I : S_SIR;
		S_E1I: state_d = s_tms ? S_UIR : S_PIR;
		S_PIR: state_d = s_tms ? S_E2I : S_PIR;
		S_E2I: state_d = s_tms ? S_UIR : S_SIR;
		S_UIR: state_d = s_tms ? S_SDS : S_RTI;
		default: state_d = S_TLR;
		endcase
	end

	always @* begin
		if (sel_ext | sel_smp)
			dr_out = bsr_sh_q[0];
		else if (sel_id | sel_usr)
			dr_out = id_sh_q[0];
		else if (sel_prb)
			dr_out = prb_sh_q[0];
		else
			dr_out = byp_q;
	end

	always @(posedge clk) begin
		if (!nrst) begin
			tck_prev_q <= 1'b0;
			state_q <= S_TLR;
			ir_q <= `BSJ_OP_IDCODE;
			ir_sh_q <= {`BSJ_IR_W{1'b0}};
			byp_q <= 1'b0;
			id_sh_q <= 32'h0000_0000;
			bsr_sh_q <= {BL{1'b0}};
			bsr_upd_q <= {NO{1'b0}};
			prb_sh_q <= {PW{1'b0}};
			cfg_start_q <= 1'b0;
			cfg_bit_q <= 1'b0;
			cfg_stb_q <= 1'b0;
		end else begin
			tck_prev_q <= s_tck;
			cfg_start_q <= 1'b0;
			cfg_stb_q <= 1'b0;
			if (tck_rise) begin
				state_q <= state_d;
				case (state_q)
				S_TLR: ir_q <= `BSJ_OP_IDCODE;
				S_CIR: ir_sh_q <= `BSJ_IR_CAPTURE;
				S_SIR: ir_sh_q <= {s_tdi, ir_sh_q[`BSJ_IR_W-1:1]};
				S_UIR: begin
					ir_q <= ir_sh_q;
					cfg_start_q <= (ir_sh_q == `BSJ_OP_CFG_START);
				end
				S_CDR: begin
					byp_q <= 1'b0;
					if (sel_id)
						id_sh_q <= IDCODE;
					if (sel_usr)
						id_sh_q <= USERCODE;
					if (sel_ext | sel_smp)
						bsr_sh_q <= {s_pin, core_out};
					if (sel_prb)
						prb_sh_q <= probe_in;
				end
				S_SDR: begin
					byp_q <= s_tdi;
					if (sel_id | sel_usr)
						id_sh_q <= {s_tdi, id_sh_q[31:1]};
					if (sel_ext | sel_smp)
						bsr_sh_q <= {s_tdi, bsr_sh_q[BL-1:1]};
					if (sel_prb)
						prb_sh_q <= {s_tdi, prb_sh_q[PW-1:1]};
					if (sel_cfg) begin
						cfg_bit_q <= s_tdi;
						cfg_stb_q <= 1'b1;
					end
				end
				S_UDR: begin
					if (sel_ext | sel_smp)
						bsr_upd_q <= bsr_sh_q[NO-1:0];
				end
				default: begin
				end
				endcase
			end
		end
	end

	// pins follow the core unless extest drives the preloaded pattern
	always @(posedge clk) begin
		if (!nrst) begin
			pin_out_q <= {NO{1'b0}};
			extest_q <= 1'b0;
		end else begin
			extest_q <= sel_ext;
			pin_out_q <= sel_ext ? bsr_upd_q : core_out;
		end
	end

	// serial output changes on the falling test clock
	always @(posedge clk) begin
		if (!nrst) begin
			tdo_q <= 1'b0;
			tdo_oe_n_q <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n_q <= ~((state_q == S_SDR) | (state_q == S_SIR));
			tdo_q <= (state_q == S_SIR) ? ir_sh_q[0] : dr_out;
		end
	end
endmodule // bsj_tap

// file: testbench/boundary_scan_test_port_bench.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`include "bsj_defs.vh"
module boundary_scan_test_port_bench;
	logic clk = 0, nrst = 0, cfg_busy = 0;
	logic [7:0] pin_in = 8'h5A, core_out = 8'h96;
	logic [15:0] probe_in = 16'h3C5A;
	logic [31:0] cbits = 0, r;
	wire tck, tms, tdi, tdo_q, tdo_oe_n_q, extest_q, cfg_start_q, cfg_bit_q, cfg_stb_q;
	wire [7:0] pin_out_q;
	int err_total = 0, samples_checked = 0, nst = 0, ncfg = 0;
	initial forever #5 clk = ~clk;
	bsj_tap #(.USERCODE(32'h0000A5C3)) u_dut(.clk(clk), .nrst(nrst), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo_q(tdo_q), .tdo_oe_n_q(tdo_oe_n_q), .pin_in(pin_in), .core_out(core_out),
		.pin_out_q(pin_out_q), .extest_q(extest_q), .cfg_busy(cfg_busy), .cfg_start_q(cfg_start_q),
		.cfg_bit_q(cfg_bit_q), .cfg_stb_q(cfg_stb_q), .probe_in(probe_in));
	// released tdo reads as pulled high
	bsj_host u_host(.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_oe_n_q ? 1'b1 : tdo_q));
	always @(posedge clk) begin
		if (cfg_stb_q) begin
			cbits <= {cfg_bit_q, cbits[31:1]};
			ncfg <= ncfg + 1;
		end
		if (cfg_start_q) nst <= nst + 1;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_id;
		u_host.scan(`BSJ_OP_IDCODE, 0, 32, r);
		chk("idcode", r, `BSJ_IDCODE_RST);
		u_host.scan(`BSJ_OP_USERCODE, 0, 32, r);
		chk("usercode", r, 32'h0000A5C3);
		$display("id test done");
	endtask
	task t_byp;
		for (int op = 7; op < 16; op++) begin
			u_host.scan(op[3:0], 32'h5B, 8, r);
			chk("bypass", r, 32'hB6);
		end
		$display("bypass test done");
	endtask
	task t_pins;
		u_host.scan(`BSJ_OP_SAMPLE, 32'hE1C3, 16, r);
		chk("sample", r, {16'h0, pin_in, core_out});
		chk("pins_normal", pin_out_q, core_out);
		u_host.scan(`BSJ_OP_EXTEST, 32'h7E3C, 16, r);
		chk("extest_in", r[15:8], pin_in);
		chk("extest_out", pin_out_q, 8'h3C);
		chk("extest_on", extest_q, 1);
		cfg_busy = 1;
		u_host.scan(`BSJ_OP_EXTEST, 32'h5B, 8, r);
		chk("busy_path", r, 32'hB6);
		chk("busy_extest", extest_q, 0);
		cfg_busy = 0;
		$display("pin test done");
	endtask
	task t_cfg;
		u_host.scan(`BSJ_OP_CFG_START, 0, 1, r);
		chk("cfg_start", nst, 1);
		u_host.scan(`BSJ_OP_CFG_LOAD, 32'hB4, 8, r);
		chk("cfg_count", ncfg, 8);
		chk("cfg_bits", cbits[31:24], 8'hB4);
		chk("cfg_tdo", r, 32'h68);
		u_host.scan(`BSJ_OP_PROBE, 0, 16, r);
		chk("probe", r, probe_in);
		$display("config and probe test done");
	endtask
	initial begin
		repeat (3) @(negedge clk);
		nrst = 1;
		repeat (3) @(negedge clk);
		u_host.reset();
		t_id;
		t_byp;
		t_pins;
		t_cfg;
		complete_run;
	end
	initial begin
		// the scans need well under 100 us; allow twice that before giving up
		#200us;
		err_total++;
		complete_run;
	end
endmodule // boundary_scan_test_port_bench

// file: testbench/bsj_host.sv
// external scan controller model driving the test port
`timescale 1ns/10ps
module bsj_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire tdo
);
	logic o;
	initial begin
		tck = 0;
		tms = 1;
		tdi = 1;
	end
	// tdo is read just before tck rises, once the port has settled it after the fall
	// tdi turns over once its hold has passed, never in the same step as a new bit
	task step(input t, input d);
		tms = t;
		tdi = d;
		#80;
		o = tdo;
		tck = 1;
		#40;
		tdi = ~d;
		#40;
		tck = 0;
	endtask
	task reset;
		repeat (5) step(1, 1);
		step(0, 1);
	endtask
	task scan(input [3:0] ir, input [31:0] din, input int n, output logic [31:0] dout);
		step(1, 1); step(1, 1); step(0, 1); step(0, 1);
		for (int i = 0; i < 4; i++) step(i == 3, ir[i]);
		step(1, 1); step(0, 1); step(1, 1); step(0, 1); step(0, 1);
		dout = 0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i]);
			dout[i] = o;
		end
		step(1, 1); step(0, 1);
	endtask
endmodule // bsj_host

// file: testbench/bsj_tap_assertions.sv
// checker for the boundary-scan test port outputs
`timescale 1ns/10ps
module bsj_tap_chk #(
	parameter NO = 8
) (
	input wire clk,
	input wire nrst,
	input wire tck,
	input wire tdo_q,
	input wire tdo_oe_n_q,
	input wire [NO-1:0] core_out,
	input wire [NO-1:0] pin_out_q,
	input wire extest_q,
	input wire cfg_busy,
	input wire cfg_start_q,
	input wire cfg_stb_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	chk_reset_values: assert property ($rose(nrst) |-> tdo_oe_n_q && !tdo_q && !extest_q
		&& pin_out_q == 0 && !cfg_stb_q) else $error("outputs not at reset values");
	chk_pins_follow_core: assert property (!extest_q [*3] |-> pin_out_q == $past(core_out))
		else $error("pins not following core");
	chk_stb_one_clk: assert property (cfg_stb_q |=> !cfg_stb_q [*2])
		else $error("config strobe too long");
	chk_start_one_clk: assert property (cfg_start_q |=> !cfg_start_q)
		else $error("config start too long");
	chk_stb_in_shift: assert property (cfg_stb_q |-> !tdo_oe_n_q)
		else $error("config strobe outside shift");
	chk_tdo_on_fall: assert property ($changed(tdo_q) |-> !$past(tck) && !$past(tck, 2))
		else $error("tdo moved outside tck low");
	chk_oe_on_fall: assert property ($changed(tdo_oe_n_q) |-> !$past(tck) && !$past(tck, 2))
		else $error("tdo enable moved outside tck low");
	chk_extest_not_busy: assert property ($rose(extest_q) |-> !$past(cfg_busy))
		else $error("extest entered while configuring");
endmodule // bsj_tap_chk
bind bsj_tap bsj_tap_chk #(.NO(NO)) u_chk(.clk(clk), .nrst(nrst), .tck(tck), .tdo_q(tdo_q),
	.tdo_oe_n_q(tdo_oe_n_q), .core_out(core_out), .pin_out_q(pin_out_q), .extest_q(extest_q),
	.cfg_busy(cfg_busy), .cfg_start_q(cfg_start_q), .cfg_stb_q(cfg_stb_q));
